// file: core/alu_datapath.v
// Operation
// - Signed divide: 16/8 or 32/16 bits, quotient low, remainder high.
// - Compare subtracts source or immediate from destination, sets flags.
// - Negate writes zero minus destination, any size.
// - Zero extend widens low byte or low word with zeros.
// - Sign extend widens low byte or word copying its top bit.
// - AND destination with register or immediate.
// - OR destination with register or immediate.
// - XOR destination with register or immediate.
// - NOT inverts every destination bit.
// - Arithmetic shifts; right shift keeps the sign bit.
// - Logical shifts insert zero at the vacated end.
// - Rotates within operand width, carry not in loop.
// - Rotates through carry include carry in the loop.
// - Bit ops on a byte; bit number from immediate or register.
// - Bit set forces the selected bit to one.
// - Bit clear forces the selected bit to zero.
// - Bit invert complements the selected bit.
// - Bit test loads zero flag with inverse of the bit.
// - Carry becomes carry AND selected bit.
// - Carry becomes carry OR selected bit.
// - Carry becomes carry AND inverted bit; immediate bit number only.
// - Carry becomes carry OR inverted bit; immediate bit number only.
`timescale 1ns/1ps
`include "alu_consts.vh"

module alu_datapath #(
   parameter AW = 24
) (
   input  wire          mclk_i,
   input  wire          nrst_i,
   input  wire          start_i,
   input  wire [4:0]    op_i,
   input  wire [1:0]    size_i,
   input  wire [31:0]   dst_i,
   input  wire [31:0]   src_i,
   input  wire [31:0]   imm_i,
   input  wire          use_imm_i,
   input  wire          mem_op_i,
   input  wire [AW-1:0] mem_addr_i,
   input  wire [3:0]    flags_i,
   input  wire [7:0]    mem_rdata_i,
   input  wire          mem_rvalid_i,
   output reg           busy_o,
   output reg           done_o,
   output reg  [31:0]   res_o,
   output reg           res_we_o,
   output reg  [3:0]    flags_o,
   output reg           flags_we_o,
   output reg           mem_rd_o,
   output reg           mem_wr_o,
   output reg  [AW-1:0] mem_addr_o,
   output reg  [7:0]    mem_wdata_o
);
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_EXEC  = 3'h1;
   localparam [2:0] S_DIVW  = 3'h2;
   localparam [2:0] S_MWAIT = 3'h3;
   localparam [2:0] S_MMOD  = 3'h4;

   // Mask of the bits an operation of the given size owns.
   function [31:0] sz_mask;
      input [1:0] sz;
      begin
         case (sz)
            `SZ_BYTE: sz_mask = 32'h0000_00FF;
            `SZ_WORD: sz_mask = 32'h0000_FFFF;
            default:  sz_mask = 32'hFFFF_FFFF;
         endcase
      end
   endfunction

   // Index of the sign bit for the given size.
   function [4:0] sz_top;
      input [1:0] sz;
      begin
         case (sz)
            `SZ_BYTE: sz_top = 5'h07;
            `SZ_WORD: sz_top = 5'h0F;
            default:  sz_top = 5'h1F;
         endcase
      end
   endfunction

   // One-place right shift that places fill at the sign position of the size.
   function [31:0] shr1;
      input [31:0] v;
      input [1:0]  sz;
      input        fill;
      reg   [31:0] r;
      begin
         r           = v >> 1;
         r[sz_top(sz)] = fill;
         shr1        = r;
      end
   endfunction

   reg         rst_meta_q;
   reg         rst_n_q;
   reg  [2:0]  state_q;
   reg  [4:0]  op_q;
   reg  [1:0]  size_q;
   reg  [31:0] dst_q;
   reg  [31:0] opnd_q;
   reg  [2:0]  bitno_q;
   reg         mem_q;
   reg  [3:0]  flg_q;
   reg  [7:0]  mbyte_q;
   reg  [31:0] alu_r;
   reg  [3:0]  alu_f;
   reg         alu_wr;
   reg  [31:0] mask;
   reg  [4:0]  top;
   reg  [32:0] diff;
   reg  [31:0] sa;
   reg  [31:0] sb;
   wire        div_done;
   wire [15:0] div_quo;
   wire [15:0] div_rem;
   wire        div_start = (state_q == S_EXEC) && (op_q == `OP_SIGNED_DIVIDE);
   wire [7:0]  bit_in    = (state_q == S_MMOD) ? mbyte_q : dst_q[7:0];
   wire [7:0]  bit_out;
   wire        bit_wr;
   wire        bit_z;
   wire        bit_zwe;
   wire        bit_c;
   wire        bit_cwe;
   wire        is_bit    = (op_q >= `OP_BIT_SET_ONE) && (op_q <= `OP_BIT_OR_INV_C);
   wire        inv_c_op  = (op_i == `OP_BIT_AND_INV_C) || (op_i == `OP_BIT_OR_INV_C);

   // Reset release is synchronised; the first stage feeds only the second.
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   sdiv_unit u_div (
      .clk_i       (mclk_i),
      .rst_n_i     (rst_n_q),
      .start_i     (div_start),
      .wide_i      (size_q != `SZ_BYTE),
      .dividend_i  (dst_q),
      .divisor_i   (opnd_q[15:0]),
      .done_o      (div_done),
      .quotient_o  (div_quo),
      .remainder_o (div_rem)
   );

   bit_unit u_bit (
      .byte_i     (bit_in),
      .bitno_i    (bitno_q),
      .op_i       (op_q),
      .carry_i    (flg_q[`FLG_C]),
      .byte_o     (bit_out),
      .write_o    (bit_wr),
      .zero_o     (bit_z),
      .zero_we_o  (bit_zwe),
      .carry_o    (bit_c),
      .carry_we_o (bit_cwe)
   );

   // Arithmetic, logic and shift results for the latched operation.
   always @* begin
      mask   = sz_mask(size_q);
      top    = sz_top(size_q);
      alu_r  = dst_q;
      alu_f  = flg_q;
      alu_wr = 1'b1;
      sa     = dst_q;
      sb     = opnd_q;
      if (op_q == `OP_NEGATE) begin
         sa = 32'h0000_0000;
         sb = dst_q;
      end
      diff = {1'b0, sa & mask} - {1'b0, sb & mask};
      case (op_q)
         `OP_COMPARE, `OP_NEGATE: begin
            alu_r        = diff[31:0];
            alu_f[`FLG_C] = (sa & mask) < (sb & mask);
            alu_f[`FLG_V] = (sa[top] ^ sb[top]) & (sa[top] ^ diff[top]);
            alu_wr       = (op_q == `OP_NEGATE);
         end
         `OP_ZERO_EXT: begin
            alu_r        = (size_q == `SZ_WORD) ? {24'h00_0000, dst_q[7:0]}
                                                : {16'h0000, dst_q[15:0]};
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_SIGN_EXT: begin
            alu_r        = (size_q == `SZ_WORD) ? {{24{dst_q[7]}}, dst_q[7:0]}
                                                : {{16{dst_q[15]}}, dst_q[15:0]};
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_AND: begin
            alu_r        = dst_q & opnd_q;
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_OR: begin
            alu_r        = dst_q | opnd_q;
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_XOR: begin
            alu_r        = dst_q ^ opnd_q;
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_NOT: begin
            alu_r        = ~dst_q;
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_ARITH_SL: begin
            alu_r        = {dst_q[30:0], 1'b0};
            alu_f[`FLG_C] = dst_q[top];
            alu_f[`FLG_V] = dst_q[top] ^ dst_q[top - 5'h01];
         end
         `OP_ARITH_SR: begin
            alu_r        = shr1(dst_q, size_q, dst_q[top]);
            alu_f[`FLG_C] = dst_q[0];
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_LOGIC_SL: begin
            alu_r        = {dst_q[30:0], 1'b0};
            alu_f[`FLG_C] = dst_q[top];
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_LOGIC_SR: begin
            alu_r        = shr1(dst_q, size_q, 1'b0);
            alu_f[`FLG_C] = dst_q[0];
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_ROT_L: begin
            alu_r        = {dst_q[30:0], dst_q[top]};
            alu_f[`FLG_C] = dst_q[top];
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_ROT_R: begin
            alu_r        = shr1(dst_q, size_q, dst_q[0]);
            alu_f[`FLG_C] = dst_q[0];
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_ROT_L_CARRY: begin
            alu_r        = {dst_q[30:0], flg_q[`FLG_C]};
            alu_f[`FLG_C] = dst_q[top];
            alu_f[`FLG_V] = 1'b0;
         end
         `OP_ROT_R_CARRY: begin
            alu_r        = shr1(dst_q, size_q, flg_q[`FLG_C]);
            alu_f[`FLG_C] = dst_q[0];
            alu_f[`FLG_V] = 1'b0;
         end
         default: begin
            alu_wr = 1'b0;
         end
      endcase
      alu_f[`FLG_N] = alu_r[top];
      alu_f[`FLG_Z] = ((alu_r & mask) == 32'h0000_0000);
   end

   // Sequencer: operands are latched when a request is taken and mem_addr_i in the
   // next cycle, after which the decoder may move on while a divide or memory access is in flight.
   always @(posedge mclk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q     <= S_IDLE;
         op_q        <= 5'h00;
         size_q      <= `SZ_BYTE;
         dst_q       <= `RST_WORD;
         opnd_q      <= `RST_WORD;
         bitno_q     <= 3'h0;
         mem_q       <= 1'b0;
         flg_q       <= `RST_FLAGS;
         mbyte_q     <= 8'h00;
         busy_o      <= 1'b0;
         done_o      <= 1'b0;
         res_o       <= `RST_WORD;
         res_we_o    <= 1'b0;
         flags_o     <= `RST_FLAGS;
         flags_we_o  <= 1'b0;
         mem_rd_o    <= 1'b0;
         mem_wr_o    <= 1'b0;
         mem_addr_o  <= {AW{1'b0}};
         mem_wdata_o <= 8'h00;
      end else begin
         done_o     <= 1'b0;
         res_we_o   <= 1'b0;
         flags_we_o <= 1'b0;
         mem_rd_o   <= 1'b0;
         mem_wr_o   <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (start_i) begin
                  op_q    <= op_i;
                  size_q  <= size_i;
                  dst_q   <= dst_i;
                  opnd_q  <= use_imm_i ? imm_i : src_i;
                  bitno_q <= (use_imm_i || inv_c_op) ? imm_i[2:0] : src_i[2:0];
                  mem_q   <= mem_op_i;
                  flg_q   <= flags_i;
                  busy_o  <= 1'b1;
                  state_q <= S_EXEC;
               end
            end
            S_EXEC: begin
               if (op_q == `OP_SIGNED_DIVIDE) begin
                  state_q <= S_DIVW;
               end else if (is_bit && mem_q) begin
                  mem_rd_o   <= 1'b1;
                  mem_addr_o <= mem_addr_i;
                  state_q    <= S_MWAIT;
               end else if (is_bit) begin
                  res_o      <= {dst_q[31:8], bit_out};
                  res_we_o   <= bit_wr;
                  flags_o    <= {flg_q[3], bit_zwe ? bit_z : flg_q[2], flg_q[1],
                                 bit_cwe ? bit_c : flg_q[0]};
                  flags_we_o <= bit_zwe | bit_cwe;
                  done_o     <= 1'b1;
                  busy_o     <= 1'b0;
                  state_q    <= S_IDLE;
               end else begin
                  res_o      <= (dst_q & ~sz_mask(size_q)) | (alu_r & sz_mask(size_q));
                  res_we_o   <= alu_wr;
                  flags_o    <= alu_f;
                  flags_we_o <= 1'b1;
                  done_o     <= 1'b1;
                  busy_o     <= 1'b0;
                  state_q    <= S_IDLE;
               end
            end
            S_DIVW: begin
               if (div_done) begin
                  if (size_q == `SZ_BYTE) begin
                     res_o <= {dst_q[31:16], div_rem[7:0], div_quo[7:0]};
                  end else begin
                     res_o <= {div_rem, div_quo};
                  end
                  res_we_o   <= 1'b1;
                  flags_o    <= {(size_q == `SZ_BYTE) ? div_quo[7] : div_quo[15],
                                 (size_q == `SZ_BYTE) ? (opnd_q[7:0] == 8'h00)
                                                      : (opnd_q[15:0] == 16'h0000),
                                 flg_q[1:0]};
                  flags_we_o <= 1'b1;
                  done_o     <= 1'b1;
                  busy_o     <= 1'b0;
                  state_q    <= S_IDLE;
               end
            end
            S_MWAIT: begin
               if (mem_rvalid_i) begin
                  mbyte_q <= mem_rdata_i;
                  state_q <= S_MMOD;
               end
            end
            S_MMOD: begin
               mem_wr_o    <= bit_wr;
               mem_wdata_o <= bit_out;
               flags_o     <= {flg_q[3], bit_zwe ? bit_z : flg_q[2], flg_q[1],
                               bit_cwe ? bit_c : flg_q[0]};
               flags_we_o  <= bit_zwe | bit_cwe;
               done_o      <= 1'b1;
               busy_o      <= 1'b0;
               state_q     <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule // alu_datapath

// file: core/alu_consts.vh
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH

// Operation codes presented on op_i.
`define OP_SIGNED_DIVIDE  5'h00
`define OP_COMPARE        5'h01
`define OP_NEGATE         5'h02
`define OP_ZERO_EXT       5'h03
`define OP_SIGN_EXT       5'h04
`define OP_AND            5'h05
`define OP_OR             5'h06
`define OP_XOR            5'h07
`define OP_NOT            5'h08
`define OP_ARITH_SL       5'h09
`define OP_ARITH_SR       5'h0A
`define OP_LOGIC_SL       5'h0B
`define OP_LOGIC_SR       5'h0C
`define OP_ROT_L          5'h0D
`define OP_ROT_R          5'h0E
`define OP_ROT_L_CARRY    5'h0F
`define OP_ROT_R_CARRY    5'h10
`define OP_BIT_SET_ONE    5'h11
`define OP_BIT_CLEAR_ZERO 5'h12
`define OP_BIT_INVERT     5'h13
`define OP_BIT_TEST_Z     5'h14
`define OP_BIT_AND_C      5'h15
`define OP_BIT_AND_INV_C  5'h16
`define OP_BIT_OR_C       5'h17
`define OP_BIT_OR_INV_C   5'h18

// Operand sizes presented on size_i.
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2

// Flag positions inside the condition code flags nibble {N,Z,V,C}.
`define FLG_C 0
`define FLG_V 1
`define FLG_Z 2
`define FLG_N 3

// Reset values and divider step count.
`define RST_WORD  32'h0000_0000
`define RST_FLAGS 4'h0
`define DIV_STEPS 6'h20

`endif

// file: core/sdiv_unit.v
`timescale 1ns/1ps
`include "alu_consts.vh"

module sdiv_unit (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        start_i,
   input  wire        wide_i,
   input  wire [31:0] dividend_i,
   input  wire [15:0] divisor_i,
   output reg         done_o,
   output reg  [15:0] quotient_o,
   output reg  [15:0] remainder_o
);
   reg  [31:0] quo_q;
   reg  [16:0] rem_q;
   reg  [15:0] dv_q;
   reg  [5:0]  cnt_q;
   reg         qneg_q;
   reg         rneg_q;
   reg         run_q;
   reg         fin_q;
   wire        nd_neg = wide_i ? dividend_i[31] : dividend_i[15];
   wire        dv_neg = wide_i ? divisor_i[15] : divisor_i[7];
   wire [31:0] nd_ext = wide_i ? dividend_i : {{16{dividend_i[15]}}, dividend_i[15:0]};
   wire [15:0] dv_ext = wide_i ? divisor_i : {{8{divisor_i[7]}}, divisor_i[7:0]};
   wire [16:0] trial  = {rem_q[15:0], quo_q[31]} - {1'b0, dv_q};

   // Restoring division on magnitudes; signs are reapplied at the end, so the
   // quotient truncates toward zero and the remainder takes the dividend's sign.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         quo_q       <= `RST_WORD;
         rem_q       <= 17'h0_0000;
         dv_q        <= 16'h0000;
         cnt_q       <= 6'h00;
         qneg_q      <= 1'b0;
         rneg_q      <= 1'b0;
         run_q       <= 1'b0;
         fin_q       <= 1'b0;
         done_o      <= 1'b0;
         quotient_o  <= 16'h0000;
         remainder_o <= 16'h0000;
      end else begin
         done_o <= 1'b0;
         fin_q  <= run_q && (cnt_q == 6'h01);
         if (start_i) begin
            quo_q  <= nd_neg ? (32'h0000_0000 - nd_ext) : nd_ext;
            dv_q   <= dv_neg ? (16'h0000 - dv_ext) : dv_ext;
            rem_q  <= 17'h0_0000;
            cnt_q  <= `DIV_STEPS;
            qneg_q <= nd_neg ^ dv_neg;
            rneg_q <= nd_neg;
            run_q  <= 1'b1;
         end else if (run_q) begin
            if (!trial[16]) begin
               rem_q <= trial;
               quo_q <= {quo_q[30:0], 1'b1};
            end else begin
               rem_q <= {rem_q[15:0], quo_q[31]};
               quo_q <= {quo_q[30:0], 1'b0};
            end
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               run_q <= 1'b0;
            end
         end else if (fin_q) begin
            quotient_o  <= qneg_q ? (16'h0000 - quo_q[15:0]) : quo_q[15:0];
            remainder_o <= rneg_q ? (16'h0000 - rem_q[15:0]) : rem_q[15:0];
            done_o      <= 1'b1;
         end
      end
   end
endmodule // sdiv_unit

// file: core/bit_unit.v
`timescale 1ns/1ps
`include "alu_consts.vh"

module bit_unit (
   input  wire [7:0] byte_i,
   input  wire [2:0] bitno_i,
   input  wire [4:0] op_i,
   input  wire       carry_i,
   output reg  [7:0] byte_o,
   output reg        write_o,
   output reg        zero_o,
   output reg        zero_we_o,
   output reg        carry_o,
   output reg        carry_we_o
);
   reg [7:0] sel;
   reg       b;

   // Single-bit manipulation on a byte; untouched bits pass straight through.
   always @* begin
      sel        = 8'h01 << bitno_i;
      b          = byte_i[bitno_i];
      byte_o     = byte_i;
      write_o    = 1'b0;
      zero_o     = 1'b0;
      zero_we_o  = 1'b0;
      carry_o    = carry_i;
      carry_we_o = 1'b0;
      case (op_i)
         `OP_BIT_SET_ONE: begin
            byte_o  = byte_i | sel;
            write_o = 1'b1;
         end
         `OP_BIT_CLEAR_ZERO: begin
            byte_o  = byte_i & ~sel;
            write_o = 1'b1;
         end
         `OP_BIT_INVERT: begin
            byte_o  = byte_i ^ sel;
            write_o = 1'b1;
         end
         `OP_BIT_TEST_Z: begin
            zero_o    = ~b;
            zero_we_o = 1'b1;
         end
         `OP_BIT_AND_C: begin
            carry_o    = carry_i & b;
            carry_we_o = 1'b1;
         end
         `OP_BIT_AND_INV_C: begin
            carry_o    = carry_i & ~b;
            carry_we_o = 1'b1;
         end
         `OP_BIT_OR_C: begin
            carry_o    = carry_i | b;
            carry_we_o = 1'b1;
         end
         `OP_BIT_OR_INV_C: begin
            carry_o    = carry_i | ~b;
            carry_we_o = 1'b1;
         end
         default: byte_o = byte_i;
      endcase
   end
endmodule // bit_unit

// file: bench/mem_byte_model.sv
`timescale 1ns/1ps

module mem_byte_model #(
   parameter AW = 24
) (
   input  wire          clk_i,
   input  wire          rd_i,
   input  wire [AW-1:0] addr_i,
   input  wire [3:0]    lat_i,
   output reg  [7:0]    rdata_o,
   output reg           rvalid_o
);
   reg [3:0]    cnt_q  = 4'h0;
   reg [AW-1:0] addr_q = {AW{1'b0}};

   initial begin
      rdata_o = 8'h00;
      rvalid_o = 1'b0;
   end

   // answer byte reads
   // Data toggles outside the valid cycle, so a stale byte cannot pass.
   always @(posedge clk_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (cnt_q == 4'h1) begin
         rvalid_o <= 1'b1;
         rdata_o <= addr_q[7:0] ^ 8'h5A;
      end
      if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
      if (rd_i) begin
         cnt_q <= lat_i;
         addr_q <= addr_i;
      end
   end
endmodule // mem_byte_model

// file: bench/alu_datapath_asserts.sv
`timescale 1ns/1ps
`include "alu_consts.vh"

module alu_datapath_asserts #(
   parameter AW = 24
) (
   input wire          mclk_i,
   input wire          nrst_i,
   input wire          start_i,
   input wire [4:0]    op_i,
   input wire [1:0]    size_i,
   input wire [31:0]   dst_i,
   input wire          mem_op_i,
   input wire [AW-1:0] mem_addr_i,
   input wire          mem_rvalid_i,
   input wire          busy_o,
   input wire          done_o,
   input wire [31:0]   res_o,
   input wire          res_we_o,
   input wire          flags_we_o,
   input wire          mem_rd_o,
   input wire          mem_wr_o,
   input wire [AW-1:0] mem_addr_o
);
   wire       take = start_i && !busy_o;
   reg  [4:0] op_q;

   // The accepted operation is kept, since the inputs may move on.
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         op_q <= 5'h00;
      end else if (take) begin
         op_q <= op_i;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   a_cmp_no_write: assert property (take && op_i == `OP_COMPARE
      |-> ##2 done_o && flags_we_o && !res_we_o) else $error("compare wrote a register");
   a_neg_long_res: assert property (take && op_i == `OP_NEGATE && size_i == `SZ_LONG
      |-> ##2 res_o == 32'h0 - $past(dst_i, 2)) else $error("negate result wrong");
   a_not_long_res: assert property (take && op_i == `OP_NOT && size_i == `SZ_LONG
      |-> ##2 res_o == ~$past(dst_i, 2)) else $error("not result wrong");
   a_zext_zero_fill: assert property (take && op_i == `OP_ZERO_EXT && size_i == `SZ_WORD
      |-> ##2 res_o[15:8] == 8'h00) else $error("zero extend upper byte not zero");
   a_sext_sign_fill: assert property (take && op_i == `OP_SIGN_EXT && size_i == `SZ_WORD
      |-> ##2 res_o[15:8] == {8{res_o[7]}}) else $error("sign extend fill wrong");
   a_div_done_bound: assert property (take && op_i == `OP_SIGNED_DIVIDE
      |-> ##[2:40] done_o) else $error("divide did not finish");
   a_mem_read_addr: assert property (take && mem_op_i
      |-> ##2 mem_rd_o && mem_addr_o == $past(mem_addr_i)) else $error("memory read missing");
   a_mem_write_back: assert property (busy_o && mem_rvalid_i && op_q == `OP_BIT_SET_ONE
      |-> ##2 mem_wr_o && done_o && !res_we_o) else $error("memory write back missing");

   c_divide: cover property (take && op_i == `OP_SIGNED_DIVIDE);
   c_mem_write: cover property (mem_wr_o);
   c_flag_only: cover property (done_o && flags_we_o && !res_we_o);
endmodule // alu_datapath_asserts

bind alu_datapath alu_datapath_asserts #(.AW(AW)) u_chk (.*);

// file: bench/alu_datapath_tb_top.sv
`timescale 1ns/1ps
`include "alu_consts.vh"

module alu_datapath_tb_top;
   reg         mclk_i = 1'b0, nrst_i = 1'b0, start_i = 1'b0;
   reg  [4:0]  op_i = 5'h00;
   reg  [1:0]  size_i = 2'h0;
   reg  [31:0] dst_i = 32'h0, src_i = 32'h0, imm_i = 32'h0;
   reg         use_imm_i = 1'b0, mem_op_i = 1'b0;
   reg  [23:0] mem_addr_i = 24'h0;
   reg  [3:0]  flags_i = 4'h0, lat = 4'h1;
   wire [7:0]  mem_rdata_i, mem_wdata_o;
   wire [3:0]  flags_o;
   wire [31:0] res_o;
   wire [23:0] mem_addr_o;
   wire        mem_rvalid_i, busy_o, done_o, res_we_o, flags_we_o, mem_rd_o, mem_wr_o;
   integer     n_fail = 0, comparisons = 0, o, s;

   alu_datapath #(.AW(24)) DUT (.*);
   mem_byte_model #(.AW(24)) u_mem (.clk_i(mclk_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
      .lat_i(lat), .rdata_o(mem_rdata_i), .rvalid_o(mem_rvalid_i));

   always #2.5 mclk_i = ~mclk_i;

   task check(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         comparisons++;
         if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   task stop_test;
      begin
         $display("comparisons %0d n_fail %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask

   // Reference: result, write flag, flag mask and flags from the operands.
   task automatic model(output [31:0] r, output we, output [3:0] fm, output [3:0] fx);
      integer w, q, rm;
      reg [31:0] m, d, b, t, v;
      reg [2:0] n;
      reg c, bt;
      begin
         w = (size_i == `SZ_BYTE) ? 8 : (size_i == `SZ_WORD) ? 16 : 32;
         m = 32'hFFFFFFFF >> (32 - w);
         d = dst_i & m;
         b = (use_imm_i ? imm_i : src_i) & m;
         t = (d - b) & m;
         c = flags_i[`FLG_C];
         n = (use_imm_i || op_i == `OP_BIT_AND_INV_C || op_i == `OP_BIT_OR_INV_C) ?
             imm_i[2:0] : src_i[2:0];
         v = mem_op_i ? {24'h0, mem_addr_i[7:0] ^ 8'h5A} : {24'h0, dst_i[7:0]};
         bt = v[n];
         we = 1'b1; fm = 4'h0; fx = 4'h0; r = d;
         case (op_i)
            `OP_SIGNED_DIVIDE: begin
               if (w == 8) begin
                  q = $signed(dst_i[15:0]) / $signed(src_i[7:0]);
                  rm = $signed(dst_i[15:0]) % $signed(src_i[7:0]);
                  r = {16'h0, rm[7:0], q[7:0]}; m = 32'hFFFF;
               end else begin
                  q = $signed(dst_i) / $signed(src_i[15:0]);
                  rm = $signed(dst_i) % $signed(src_i[15:0]);
                  r = {rm[15:0], q[15:0]}; m = 32'hFFFFFFFF;
               end
               fm = 4'h8; fx[3] = (q < 0);
            end
            `OP_COMPARE: begin
               we = 1'b0; fm = 4'hD;
               fx[3] = t[w-1]; fx[2] = (t == 0); fx[0] = (b > d);
            end
            `OP_NEGATE: r = 32'h0 - d;
            `OP_ZERO_EXT: r = d & (m >> (w / 2));
            `OP_SIGN_EXT: r = d[w/2-1] ? (d | (m & ~(m >> (w / 2)))) : (d & (m >> (w / 2)));
            `OP_AND: r = d & b;
            `OP_OR: r = d | b;
            `OP_XOR: r = d ^ b;
            `OP_NOT: r = ~d;
            `OP_ARITH_SL, `OP_LOGIC_SL: r = d << 1;
            `OP_ARITH_SR: r = (d >> 1) | (d & (32'h1 << (w - 1)));
            `OP_LOGIC_SR: r = d >> 1;
            `OP_ROT_L: r = (d << 1) | {31'h0, d[w-1]};
            `OP_ROT_R: r = (d >> 1) | ({31'h0, d[0]} << (w - 1));
            `OP_ROT_L_CARRY: begin r = (d << 1) | {31'h0, c}; fm = 4'h1; fx[0] = d[w-1]; end
            `OP_ROT_R_CARRY: begin
               r = (d >> 1) | ({31'h0, c} << (w - 1)); fm = 4'h1; fx[0] = d[0];
            end
            `OP_BIT_SET_ONE: r = v | (32'h1 << n);
            `OP_BIT_CLEAR_ZERO: r = v & ~(32'h1 << n);
            `OP_BIT_INVERT: r = v ^ (32'h1 << n);
            `OP_BIT_TEST_Z: begin we = 1'b0; fm = 4'h4; fx[2] = !bt; end
            `OP_BIT_AND_C: begin we = 1'b0; fm = 4'h1; fx[0] = c & bt; end
            `OP_BIT_AND_INV_C: begin we = 1'b0; fm = 4'h1; fx[0] = c & !bt; end
            `OP_BIT_OR_C: begin we = 1'b0; fm = 4'h1; fx[0] = c | bt; end
            default: begin we = 1'b0; fm = 4'h1; fx[0] = c | !bt; end
         endcase
         r = (dst_i & ~m) | (r & m);
      end
   endtask

   // One operation: random operands, start for one edge, wait bounded for done.
   task automatic run(input [4:0] op, input [1:0] sz, input mem);
      reg [31:0] er;
      reg ew;
      reg [3:0] fm, fx;
      integer k;
      begin
         @(negedge mclk_i);
         op_i = op; size_i = sz; mem_op_i = mem;
         dst_i = $urandom; src_i = $urandom; imm_i = $urandom; use_imm_i = $urandom;
         flags_i = $urandom; mem_addr_i = $urandom; lat = 4'h1 + $urandom % 4;
         // Divisor kept positive and above one so the quotient always fits.
         if (op == `OP_SIGNED_DIVIDE) begin
            use_imm_i = 1'b0;
            dst_i[31:8] = {24{dst_i[7]}};
            src_i[15:0] = {1'b0, src_i[14:0]} | 16'h0002;
            if (sz == `SZ_BYTE) src_i[7:0] = {1'b0, src_i[6:0]} | 8'h02;
            else dst_i[31:16] = {16{dst_i[15]}};
         end
         model(er, ew, fm, fx);
         start_i = 1'b1;
         @(negedge mclk_i);
         start_i = 1'b0;
         for (k = 0; k < 80 && done_o !== 1'b1; k++) begin
            @(posedge mclk_i);
            #1;
         end
         check("done", {busy_o, done_o}, 32'h1);
         if (mem) check("mem_wr", mem_wr_o, ew);
         else check("res_we", res_we_o, ew);
         if (ew && mem) check("wdata", mem_wdata_o, er[7:0]);
         if (ew && !mem) check("res", res_o, er);
         if (fm != 4'h0) check("flags", flags_o & fm, fx);
      end
   endtask

   initial begin
      void'($urandom(49593));
      repeat (5) @(posedge mclk_i);
      @(negedge mclk_i);
      nrst_i = 1'b1;
      repeat (3) @(posedge mclk_i);
      // Every code in every size it accepts: divide B/W, extends W/L, bit ops B only.
      for (o = 0; o < 25; o++) begin
         for (s = 0; s < 3; s++) begin
            if ((o == 0 && s < 2) || ((o == 3 || o == 4) && s > 0) || (o > 16 && s == 0) ||
                (o > 0 && o < 17 && o != 3 && o != 4)) begin
               repeat (4) run(o[4:0], s[1:0], 1'b0);
            end
         end
         $display("test register op %0d finished", o);
      end
      // Bit operations on a memory byte with varying read latency.
      for (o = 17; o < 25; o++) begin
         repeat (4) run(o[4:0], 2'h0, 1'b1);
         $display("test memory op %0d finished", o);
      end
      stop_test;
   end

   // Watchdog well beyond the longest expected run.
   initial begin
      #50000;
      n_fail++;
      stop_test;
   end
endmodule // alu_datapath_tb_top
